// *** core/sfs_consts.vh ***
// constants shared by the serial access, packet queue and pattern recognizer
// assumes inclusion by bare name from the design files under core/
// Summary of operation
// - frame opens with address byte: write/read bit, then seven address bits, msb first
// - data bytes move msb first, mosi for writes, miso for reads
// - with select low, more bytes follow; queue address stays, others increment
// - select high ends the frame; next frame needs a new address byte
// - on writes, miso returns the register contents before the write
// - shift register serialises queue bytes msb first, assembles received bits into bytes; code assembles in packet mode only
// - the packet queue holds exactly 66 bytes
// - not-empty low only when empty; during reads updated at select falling edge
// - full is high exactly when every queue location is occupied
// - writing into a full queue drops byte, sets overrun; clearing it empties queue
// - packet sent rises once the shift register sent its final bit
// - level flag compares fill with threshold on queue access, invalid after full
// - queue kept or cleared on mode changes as the mode table says
// - recognizer runs only when enabled; continuous mode also needs bit synchroniser
// - recognizer shifts received bits continuously and flags a pattern match
// - earliest bit meets bit 7 of first byte, latest bit 0 of last
// - match flag clears when receive is left or the queue empties
// - pattern length one to eight bytes; same pattern is sent first in transmit; code sends it in packet mode only
// - up to the programmed tolerance of zero to seven bit errors still match
// - mosi sampled on rising serial clock, miso driven on falling edge
// - miso released while select is high; transfers start with select falling
`ifndef SFS_CONSTS_VH
`define SFS_CONSTS_VH

`define SFS_QUEUE_DEPTH   7'h42
`define SFS_QUEUE_LAST    7'h41
`define SFS_QUEUE_ADDR    7'h00
`define SFS_BYTE_LAST     3'h7
`define SFS_PAT_BYTES     4'h8

`define SFS_MODE_SLEEP    3'h0
`define SFS_MODE_STDBY    3'h1
`define SFS_MODE_FS       3'h2
`define SFS_MODE_TX       3'h3
`define SFS_MODE_RX       3'h4

`endif

// *** core/sfs_queue_mem.v ***
// byte memory behind the packet queue, one write port and one registered read port
// assumes the caller keeps addresses below the queue depth
`timescale 1ns/1ns
`include "sfs_consts.vh"
module sfs_queue_mem (
  input  wire       clk_i,
  input  wire       we_i,
  input  wire [6:0] waddr_i,
  input  wire [7:0] wdata_i,
  input  wire       re_i,
  input  wire [6:0] raddr_i,
  output reg  [7:0] rdata_o
);
  reg [7:0] mem [0:`SFS_QUEUE_LAST];

  always @(posedge clk_i) begin
    if (we_i) begin
      mem[waddr_i] <= wdata_i;
    end
    if (re_i) begin
      rdata_o <= mem[raddr_i];
    end
  end
endmodule

// *** core/sfs_top.v ***
// serial register access, 66-byte packet queue with shift register, and pattern recognizer
// assumes: serial pins, bit clock and received bit come from outside and are synchronised here;
// register contents live outside, reached through reg_addr_o / reg_we_o / reg_rdata_i
`timescale 1ns/1ns
`include "sfs_consts.vh"
module sfs_top (
  input  wire        clk_i,
  input  wire        nrst_i,
  input  wire        sck_i,
  input  wire        mosi_i,
  input  wire        slave_select_n_i,
  output reg         miso_o,
  output reg         miso_oe_n_o,
  output reg  [6:0]  reg_addr_o,
  output reg  [7:0]  reg_wdata_o,
  output reg         reg_we_o,
  input  wire [7:0]  reg_rdata_i,
  input  wire [2:0]  mode_i,
  input  wire        packet_mode_i,
  input  wire        bitsync_enable_i,
  input  wire [6:0]  queue_level_threshold_i,
  input  wire        queue_overrun_clear_i,
  input  wire        pattern_detect_enable_i,
  input  wire [2:0]  pattern_length_i,
  input  wire [2:0]  pattern_error_tolerance_i,
  input  wire [63:0] pattern_value_i,
  input  wire [15:0] bit_rate_div_i,
  input  wire        rx_bit_clk_i,
  input  wire        rx_bit_i,
  output reg         tx_bit_o,
  output reg         queue_not_empty_o,
  output reg         queue_full_o,
  output reg         queue_overrun_flag_o,
  output reg         queue_level_flag_o,
  output reg         packet_sent_flag_o,
  output reg         pattern_match_flag_o
);
  localparam TX_IDLE  = 3'h0;
  localparam TX_PAT   = 3'h1;
  localparam TX_FETCH = 3'h2;
  localparam TX_WAIT  = 3'h3;
  localparam TX_SHIFT = 3'h4;
  localparam TX_DONE  = 3'h5;

  // queue pointer step with wrap at the fixed depth
  function [6:0] ptr_inc;
    input [6:0] p;
    begin
      ptr_inc = (p == `SFS_QUEUE_LAST) ? 7'h00 : p + 7'h01;
    end
  endfunction

  function [6:0] ones64;
    input [63:0] v;
    integer k;
    begin
      ones64 = 7'h00;
      for (k = 0; k < 64; k = k + 1) begin
        ones64 = ones64 + {6'h00, v[k]};
      end
    end
  endfunction

  reg rst_s1, rst_n;
  always @(posedge clk_i or negedge nrst_i) begin
    if (!nrst_i) begin
      rst_s1 <= 1'b0;
      rst_n  <= 1'b0;
    end else begin
      rst_s1 <= 1'b1;
      rst_n  <= rst_s1;
    end
  end

  // pin synchronisers; the third stage only serves edge detection
  reg sck_s1, sck_s2, sck_s3, mosi_s1, mosi_s2, nss_s1, nss_s2, nss_s3;
  reg bclk_s1, bclk_s2, bclk_s3, rxb_s1, rxb_s2;
  always @(posedge clk_i or negedge rst_n) begin
    if (!rst_n) begin
      {sck_s1, sck_s2, sck_s3, mosi_s1, mosi_s2} <= 5'h00;
      {nss_s1, nss_s2, nss_s3} <= 3'h7;
      {bclk_s1, bclk_s2, bclk_s3, rxb_s1, rxb_s2} <= 5'h00;
    end else begin
      sck_s1  <= sck_i;
      sck_s2  <= sck_s1;
      sck_s3  <= sck_s2;
      mosi_s1 <= mosi_i;
      mosi_s2 <= mosi_s1;
      nss_s1  <= slave_select_n_i;
      nss_s2  <= nss_s1;
      nss_s3  <= nss_s2;
      bclk_s1 <= rx_bit_clk_i;
      bclk_s2 <= bclk_s1;
      bclk_s3 <= bclk_s2;
      rxb_s1  <= rx_bit_i;
      rxb_s2  <= rxb_s1;
    end
  end

  wire sck_rise = sck_s2 & ~sck_s3;
  wire sck_fall = ~sck_s2 & sck_s3;
  wire nss_fall = ~nss_s2 & nss_s3;
  wire bit_tick = bclk_s2 & ~bclk_s3;

  // queue state
  reg  [6:0] wr_ptr, rd_ptr, count;
  reg        level_frozen, hold_ne;
  reg  [2:0] prev_mode;
  wire [7:0] mem_rdata;
  wire       in_rx = (mode_i == `SFS_MODE_RX);
  wire       in_tx = (mode_i == `SFS_MODE_TX);

  // serial side
  reg  [2:0] spi_bits;
  reg  [7:0] spi_in, spi_out, spi_cap;
  reg        spi_have_addr, spi_wnr, spi_fetch, spi_fetch_d, spi_fetch_dd, spi_from_q;
  reg  [6:0] spi_addr;
  reg        spi_push;
  reg  [7:0] spi_push_data;
  wire [7:0] spi_byte = {spi_in[6:0], mosi_s2};
  wire       spi_is_q = (spi_addr == `SFS_QUEUE_ADDR);

  // shift register side
  reg  [2:0] tx_state;
  reg  [7:0] tx_sr;
  reg  [2:0] tx_bits;
  reg  [3:0] tx_pat_idx;
  reg  [15:0] div_cnt;
  reg        tx_tick;
  reg  [7:0] rx_sr;
  reg  [2:0] rx_bits;
  reg        rx_push;
  reg  [63:0] hist;

  wire spi_pop  = spi_fetch & spi_is_q & ~spi_wnr & (count != 7'h00);
  wire tx_pop   = (tx_state == TX_FETCH) & (count != 7'h00);
  wire pop      = in_tx ? tx_pop : spi_pop;
  wire push_req = in_rx ? rx_push : spi_push;
  wire push_ok  = push_req & (count != `SFS_QUEUE_DEPTH);
  wire overrun  = push_req & (count == `SFS_QUEUE_DEPTH);
  wire [7:0] push_data = in_rx ? rx_sr : spi_push_data;

  // mode table: entering rx from stdby or sleep, rx to tx, and leaving tx clear the queue
  wire low_prev   = (prev_mode == `SFS_MODE_SLEEP) | (prev_mode == `SFS_MODE_STDBY);
  wire mode_clear = (mode_i != prev_mode) &
                    ((in_rx & low_prev) | ((prev_mode == `SFS_MODE_RX) & in_tx) |
                     (prev_mode == `SFS_MODE_TX));
  wire q_clear    = mode_clear | (queue_overrun_clear_i & queue_overrun_flag_o);

  wire [6:0] next_count = q_clear ? 7'h00 :
                          (push_ok & ~pop) ? count + 7'h01 :
                          (pop & ~push_ok) ? count - 7'h01 : count;

  sfs_queue_mem u_mem (
    .clk_i   (clk_i),
    .we_i    (push_ok & ~q_clear),
    .waddr_i (wr_ptr),
    .wdata_i (push_data),
    .re_i    (pop),
    .raddr_i (rd_ptr),
    .rdata_o (mem_rdata)
  );

  always @(posedge clk_i or negedge rst_n) begin
    if (!rst_n) begin
      wr_ptr               <= 7'h00;
      rd_ptr               <= 7'h00;
      count                <= 7'h00;
      prev_mode            <= `SFS_MODE_SLEEP;
      level_frozen         <= 1'b0;
      hold_ne              <= 1'b0;
      queue_not_empty_o    <= 1'b0;
      queue_full_o         <= 1'b0;
      queue_overrun_flag_o <= 1'b0;
      queue_level_flag_o   <= 1'b0;
    end else begin
      prev_mode <= mode_i;
      count     <= next_count;
      if (q_clear) begin
        wr_ptr <= 7'h00;
        rd_ptr <= 7'h00;
      end else begin
        if (push_ok) begin
          wr_ptr <= ptr_inc(wr_ptr);
        end
        if (pop) begin
          rd_ptr <= ptr_inc(rd_ptr);
        end
      end
      // set beats a clear arriving in the same cycle
      queue_overrun_flag_o <= overrun | (queue_overrun_flag_o & ~queue_overrun_clear_i);
      queue_full_o <= (next_count == `SFS_QUEUE_DEPTH);
      // host reads hold not-empty until the next select falling edge, a push or a queue clear
      if (spi_pop & ~in_tx) begin
        hold_ne <= 1'b1;
      end else if (nss_fall | q_clear | push_ok) begin
        hold_ne <= 1'b0;
      end
      if (!(hold_ne | (spi_pop & ~in_tx)) | nss_fall | q_clear | push_ok) begin
        queue_not_empty_o <= (next_count != 7'h00);
      end
      if (next_count == 7'h00) begin
        level_frozen <= 1'b0;
      end else if (next_count == `SFS_QUEUE_DEPTH) begin
        level_frozen <= 1'b1;
      end
      if (q_clear) begin
        queue_level_flag_o <= 1'b0;
      end else if ((push_ok | pop) & ~level_frozen) begin
        queue_level_flag_o <= (next_count > queue_level_threshold_i);
      end
    end
  end

  // serial frames; the sync path adds about six clocks, so sck must stay below roughly clk/12
  always @(posedge clk_i or negedge rst_n) begin
    if (!rst_n) begin
      spi_bits      <= 3'h0;
      spi_in        <= 8'h00;
      spi_out       <= 8'h00;
      spi_cap       <= 8'h00;
      spi_have_addr <= 1'b0;
      spi_wnr       <= 1'b0;
      spi_addr      <= 7'h00;
      spi_fetch     <= 1'b0;
      spi_fetch_d   <= 1'b0;
      spi_fetch_dd  <= 1'b0;
      spi_from_q    <= 1'b0;
      spi_push      <= 1'b0;
      spi_push_data <= 8'h00;
      reg_addr_o    <= 7'h00;
      reg_wdata_o   <= 8'h00;
      reg_we_o      <= 1'b0;
      miso_o        <= 1'b0;
      miso_oe_n_o   <= 1'b1;
    end else begin
      spi_push     <= 1'b0;
      reg_we_o     <= 1'b0;
      spi_fetch    <= 1'b0;
      spi_fetch_d  <= spi_fetch;
      spi_fetch_dd <= spi_fetch_d;
      miso_oe_n_o  <= nss_s2;
      if (nss_s2) begin
        spi_bits      <= 3'h0;
        spi_have_addr <= 1'b0;
        spi_out       <= 8'h00;
        miso_o        <= 1'b0;
      end else begin
        if (sck_rise) begin
          spi_in   <= spi_byte;
          spi_bits <= spi_bits + 3'h1;
          if (spi_bits == `SFS_BYTE_LAST) begin
            spi_fetch <= 1'b1;
            if (!spi_have_addr) begin
              spi_have_addr <= 1'b1;
              spi_wnr       <= spi_byte[7];
              spi_addr      <= spi_byte[6:0];
            end else begin
              if (spi_wnr & spi_is_q) begin
                spi_push      <= 1'b1;
                spi_push_data <= spi_byte;
              end else if (spi_wnr) begin
                reg_we_o    <= 1'b1;
                reg_wdata_o <= spi_byte;
              end
              if (!spi_is_q) begin
                spi_addr <= spi_addr + 7'h01;
              end
            end
          end
        end
        if (sck_fall) begin
          miso_o  <= spi_out[7];
          spi_out <= {spi_out[6:0], 1'b0};
        end
        // byte for the next data slot is fetched before the write lands
        if (spi_fetch) begin
          reg_addr_o <= spi_addr;
          spi_from_q <= spi_pop;
        end
        if (spi_fetch_d) begin
          spi_cap <= reg_rdata_i;
        end
        if (spi_fetch_dd) begin
          spi_out <= spi_from_q ? mem_rdata : (spi_is_q ? 8'h00 : spi_cap);
        end
      end
    end
  end

  // transmit bit rate enable
  always @(posedge clk_i or negedge rst_n) begin
    if (!rst_n) begin
      div_cnt <= 16'h0000;
      tx_tick <= 1'b0;
    end else begin
      tx_tick <= 1'b0;
      if (!in_tx || div_cnt >= bit_rate_div_i) begin
        div_cnt <= 16'h0000;
        tx_tick <= in_tx;
      end else begin
        div_cnt <= div_cnt + 16'h0001;
      end
    end
  end

  // transmit: optional pattern bytes, then queue bytes until the queue runs dry
  always @(posedge clk_i or negedge rst_n) begin
    if (!rst_n) begin
      tx_state           <= TX_IDLE;
      tx_sr              <= 8'h00;
      tx_bits            <= 3'h0;
      tx_pat_idx         <= 4'h0;
      tx_bit_o           <= 1'b0;
      packet_sent_flag_o <= 1'b0;
    end else if (!in_tx) begin
      tx_state           <= TX_IDLE;
      tx_bit_o           <= 1'b0;
      packet_sent_flag_o <= 1'b0;
    end else begin
      case (tx_state)
        TX_IDLE: begin
          tx_pat_idx <= 4'h0;
          tx_state   <= (packet_mode_i & pattern_detect_enable_i) ? TX_PAT : TX_FETCH;
        end
        TX_PAT: begin
          tx_sr      <= pattern_value_i[8'd63 - {tx_pat_idx[2:0], 3'h0} -: 8];
          tx_pat_idx <= tx_pat_idx + 4'h1;
          tx_bits    <= 3'h0;
          tx_state   <= TX_SHIFT;
        end
        TX_FETCH: begin
          tx_state <= (count != 7'h00) ? TX_WAIT : TX_DONE;
        end
        TX_WAIT: begin
          tx_sr    <= mem_rdata;
          tx_bits  <= 3'h0;
          tx_state <= TX_SHIFT;
        end
        TX_SHIFT: begin
          if (tx_tick) begin
            tx_bit_o <= tx_sr[7];
            tx_sr    <= {tx_sr[6:0], 1'b0};
            tx_bits  <= tx_bits + 3'h1;
            if (tx_bits == `SFS_BYTE_LAST) begin
              if ((tx_pat_idx != 4'h0) && (tx_pat_idx <= {1'b0, pattern_length_i})) begin
                tx_state <= TX_PAT;
              end else begin
                tx_pat_idx <= `SFS_PAT_BYTES;
                tx_state   <= TX_FETCH;
              end
            end
          end
        end
        TX_DONE: begin
          // wait one bit period so the last bit has left before flagging
          if (tx_tick) begin
            packet_sent_flag_o <= 1'b1;
          end
        end
        default: tx_state <= TX_IDLE;
      endcase
    end
  end

  // receive: pattern search on every bit; in packet mode, byte assembly into the queue after a match
  wire        rx_active  = in_rx & pattern_detect_enable_i & (packet_mode_i | bitsync_enable_i);
  wire [63:0] next_hist  = {hist[62:0], rxb_s2};
  wire [5:0]  pat_shift  = {3'h7 - pattern_length_i, 3'h0};
  wire [63:0] pat_expect = pattern_value_i >> pat_shift;
  wire [63:0] pat_mask   = {64{1'b1}} >> pat_shift;
  wire [6:0]  pat_errs   = ones64((next_hist ^ pat_expect) & pat_mask);
  wire        pat_hit    = rx_active & bit_tick & (pat_errs <= {4'h0, pattern_error_tolerance_i});
  wire        capture    = in_rx & packet_mode_i & (pattern_match_flag_o | ~pattern_detect_enable_i);

  always @(posedge clk_i or negedge rst_n) begin
    if (!rst_n) begin
      hist                 <= 64'h0000000000000000;
      rx_sr                <= 8'h00;
      rx_bits              <= 3'h0;
      rx_push              <= 1'b0;
      pattern_match_flag_o <= 1'b0;
    end else begin
      rx_push <= 1'b0;
      if (bit_tick) begin
        hist <= next_hist;
      end
      // a fresh match beats the clear that an emptying queue would give; leaving rx always clears
      if (pat_hit) begin
        pattern_match_flag_o <= 1'b1;
      end else if (!in_rx || (count != 7'h00 && next_count == 7'h00)) begin
        pattern_match_flag_o <= 1'b0;
      end
      if (!capture) begin
        rx_bits <= 3'h0;
      end else if (bit_tick) begin
        rx_sr   <= {rx_sr[6:0], rxb_s2};
        rx_bits <= rx_bits + 3'h1;
        rx_push <= (rx_bits == `SFS_BYTE_LAST);
      end
    end
  end
endmodule

// *** test/sfs_monitor.sv ***
// checker on the top ports of the serial access, packet queue and pattern block
// assumes it is bound to sfs_top and that reset is low at time zero
`timescale 1ns/1ns
`include "sfs_consts.vh"
module sfs_monitor (
  input wire       clk_i,
  input wire       nrst_i,
  input wire       slave_select_n_i,
  input wire       miso_o,
  input wire       miso_oe_n_o,
  input wire [6:0] reg_addr_o,
  input wire       reg_we_o,
  input wire [2:0] mode_i,
  input wire       packet_mode_i,
  input wire       bitsync_enable_i,
  input wire       queue_overrun_clear_i,
  input wire       pattern_detect_enable_i,
  input wire       queue_not_empty_o,
  input wire       queue_full_o,
  input wire       queue_overrun_flag_o,
  input wire       packet_sent_flag_o,
  input wire       pattern_match_flag_o
);
  default clocking @(posedge clk_i); endclocking
  default disable iff (!nrst_i);

  // select passes two sync flops, so four high samples are enough
  property p_miso_release;
    slave_select_n_i [*4] |-> miso_oe_n_o && !miso_o;
  endproperty
  a_miso_release: assert property (p_miso_release) else $error("miso driven while deselected");

  property p_write_target;
    reg_we_o |-> reg_addr_o != `SFS_QUEUE_ADDR && !miso_oe_n_o;
  endproperty
  a_write_target: assert property (p_write_target) else $error("register write outside frame or at queue");

  property p_burst_step;
    reg_we_o |=> reg_addr_o == $past(reg_addr_o) + 7'h01;
  endproperty
  a_burst_step: assert property (p_burst_step) else $error("burst address did not step");

  property p_full_occupied;
    queue_full_o |-> queue_not_empty_o;
  endproperty
  a_full_occupied: assert property (p_full_occupied) else $error("full while empty");

  property p_overrun_cause;
    $rose(queue_overrun_flag_o) |-> $past(queue_full_o);
  endproperty
  a_overrun_cause: assert property (p_overrun_cause) else $error("overrun without full queue");

  property p_overrun_clear;
    queue_overrun_flag_o && queue_overrun_clear_i |-> ##[1:3] !queue_overrun_flag_o && !queue_full_o;
  endproperty
  a_overrun_clear: assert property (p_overrun_clear) else $error("overrun clear failed");

  property p_sent_only_tx;
    (mode_i != `SFS_MODE_TX) [*3] |-> !packet_sent_flag_o;
  endproperty
  a_sent_only_tx: assert property (p_sent_only_tx) else $error("packet sent outside transmit");

  property p_match_cause;
    $rose(pattern_match_flag_o) |-> $past(pattern_detect_enable_i && (packet_mode_i || bitsync_enable_i))
      && $past(mode_i) == `SFS_MODE_RX;
  endproperty
  a_match_cause: assert property (p_match_cause) else $error("match while recognizer off");

  property p_match_leave_rx;
    (mode_i != `SFS_MODE_RX) [*3] |-> !pattern_match_flag_o;
  endproperty
  a_match_leave_rx: assert property (p_match_leave_rx) else $error("match held outside receive");

  c_full: cover property ($rose(queue_full_o));
  c_match: cover property ($rose(pattern_match_flag_o));
  c_sent: cover property ($rose(packet_sent_flag_o));
endmodule

// *** test/sfs_host_model.sv ***
// serial bus master standing in for the host controller, clock idle low, msb first
// assumes clk_i is the bench clock; one serial bit lasts 16 clocks
`timescale 1ns/1ns
module sfs_host_model (
  input  wire clk_i,
  input  wire miso_i,
  input  wire miso_oe_n_i,
  output reg  sck_o,
  output wire mosi_o,
  output reg  slave_select_n_o
);
  reg  bit_q;
  reg  idle_q;
  reg  last_miso;
  // a released line shows the inverse of its last level so stale data never matches
  wire miso_line = miso_oe_n_i ? ~last_miso : miso_i;
  assign mosi_o = slave_select_n_o ? idle_q : bit_q;
  initial begin
    sck_o = 1'b0;
    slave_select_n_o = 1'b1;
    bit_q = 1'b0;
    idle_q = 1'b0;
    last_miso = 1'b0;
  end
  always @(posedge clk_i) begin
    idle_q <= ~idle_q;
    if (!miso_oe_n_i)
      last_miso <= miso_i;
  end
  task tick(input integer n);
    repeat (n) @(posedge clk_i);
    #1;
  endtask
  task open_frame;
    tick(1);
    slave_select_n_o = 1'b0;
    tick(8);
  endtask
  task close_frame;
    tick(8);
    slave_select_n_o = 1'b1;
    tick(6);
  endtask
  task xfer(input [7:0] tx, output [7:0] rx);
    integer i;
    for (i = 7; i >= 0; i = i - 1) begin
      bit_q = tx[i];
      tick(8);
      sck_o = 1'b1;
      rx[i] = miso_line;
      tick(8);
      sck_o = 1'b0;
    end
  endtask
endmodule

// *** test/sfs_top_test.sv ***
// self-checking bench for sfs_top: host model on the serial pins, register file and link here
// assumes a 100 MHz clock; the whole run takes some 20000 cycles
`timescale 1ns/1ns
`include "sfs_consts.vh"
module sfs_top_test;
  reg        clk = 1'b0;
  reg        nrst = 1'b0;
  reg  [2:0] mode = `SFS_MODE_STDBY;
  reg        ovr_clr = 1'b0;
  reg        det_en = 1'b0;
  reg  [2:0] pat_len = 3'h0;
  reg  [2:0] pat_tol = 3'h0;
  reg [63:0] pat_val = 64'h96c3a55a11223344;
  reg        pkt_mode = 1'b1, bsync = 1'b0;
  reg  [6:0] lvl_thr = 7'h0a;
  reg [15:0] rate_div = 16'h0003;
  reg        rx_clk = 1'b0;
  reg        rx_bit = 1'b0;
  reg  [7:0] regs [0:127];
  reg  [7:0] rx;
  reg [15:0] tx_exp;
  wire       sck, mosi, ssn, miso, oe_n, we, tx_bit, ne, full, ovr, lvl, sent, match;
  wire [6:0] addr;
  wire [7:0] wdata;
  integer    num_errors = 0, checked = 0, cycles = 0, i;
  always #5 clk = ~clk;
  always @(posedge clk) if (we) regs[addr] <= wdata;

  sfs_host_model host (.clk_i(clk), .miso_i(miso), .miso_oe_n_i(oe_n), .sck_o(sck), .mosi_o(mosi),
    .slave_select_n_o(ssn));
  sfs_top dut (.clk_i(clk), .nrst_i(nrst), .sck_i(sck), .mosi_i(mosi), .slave_select_n_i(ssn),
    .miso_o(miso), .miso_oe_n_o(oe_n), .reg_addr_o(addr), .reg_wdata_o(wdata), .reg_we_o(we),
    .reg_rdata_i(regs[addr]), .mode_i(mode), .packet_mode_i(pkt_mode), .bitsync_enable_i(bsync),
    .queue_level_threshold_i(lvl_thr), .queue_overrun_clear_i(ovr_clr), .pattern_detect_enable_i(det_en),
    .pattern_length_i(pat_len), .pattern_error_tolerance_i(pat_tol), .pattern_value_i(pat_val),
    .bit_rate_div_i(rate_div), .rx_bit_clk_i(rx_clk), .rx_bit_i(rx_bit), .tx_bit_o(tx_bit),
    .queue_not_empty_o(ne), .queue_full_o(full), .queue_overrun_flag_o(ovr), .queue_level_flag_o(lvl),
    .packet_sent_flag_o(sent), .pattern_match_flag_o(match));

  task check_bit(input string name, input logic exp, input logic got);
    checked = checked + 1;
    if (got !== exp) begin
      num_errors = num_errors + 1;
      $display("ERROR %s expected %h seen %h", name, exp, got);
    end
  endtask
  task check_byte(input string name, input logic [7:0] exp, input logic [7:0] got);
    checked = checked + 1;
    if (got !== exp) begin
      num_errors = num_errors + 1;
      $display("ERROR %s expected %h seen %h", name, exp, got);
    end
  endtask
  task end_of_test;
    $display("compared %0d, mismatched %0d", checked, num_errors);
    if (num_errors == 0 && checked > 0)
      $display("NO MISMATCHES");
    else
      $display("MISMATCHES SEEN");
    $finish;
  endtask
  // the link clock only runs while bits are sent
  task send_rx(input [7:0] b);
    integer k;
    for (k = 7; k >= 0; k = k - 1) begin
      rx_bit = b[k];
      host.tick(8);
      rx_clk = 1'b1;
      host.tick(8);
      rx_clk = 1'b0;
    end
  endtask
  task queue_write(input [7:0] b);
    host.open_frame;
    host.xfer(8'h80, rx);
    host.xfer(b, rx);
    host.close_frame;
  endtask

  always @(posedge clk) begin
    cycles <= cycles + 1;
    if (cycles == 60000) begin
      num_errors = num_errors + 1;
      end_of_test;
    end
  end

  initial begin
    for (i = 0; i < 128; i = i + 1) regs[i] = i[7:0] ^ 8'h5a;
    host.tick(4);
    nrst = 1'b1;
    host.tick(4);
    check_bit("miso enable", 1'b1, oe_n);
    check_bit("not empty", 1'b0, ne);
    $display("reset test done");
    host.open_frame;
    host.xfer(8'h85, rx);
    host.xfer(8'ha5, rx);
    check_byte("old reg 05", 8'h05 ^ 8'h5a, rx);
    host.xfer(8'h3c, rx);
    check_byte("old reg 06", 8'h06 ^ 8'h5a, rx);
    host.close_frame;
    host.open_frame;
    host.xfer(8'h05, rx);
    host.xfer(8'h00, rx);
    check_byte("reg 05", 8'ha5, rx);
    host.xfer(8'h00, rx);
    check_byte("reg 06", 8'h3c, rx);
    host.close_frame;
    $display("register test done");
    host.open_frame;
    host.xfer(8'h80, rx);
    for (i = 0; i < 67; i = i + 1) begin
      host.xfer(i[7:0] + 8'h10, rx);
      if (i == 9 || i == 10) check_bit("level", i == 10, lvl);
      if (i == 64 || i == 65) check_bit("full", i == 65, full);
    end
    host.close_frame;
    check_bit("overrun", 1'b1, ovr);
    host.open_frame;
    host.xfer(8'h00, rx);
    for (i = 0; i < 66; i = i + 1) begin
      host.xfer(8'h00, rx);
      check_byte("queue data", i[7:0] + 8'h10, rx);
    end
    host.close_frame;
    check_bit("full", 1'b0, full);
    host.open_frame;
    check_bit("not empty", 1'b0, ne);
    host.close_frame;
    queue_write(8'h77);
    check_bit("not empty", 1'b1, ne);
    // a threshold change alone must not refresh the level flag
    lvl_thr = 7'h00;
    host.tick(2);
    check_bit("level", 1'b0, lvl);
    ovr_clr = 1'b1;
    host.tick(1);
    ovr_clr = 1'b0;
    host.tick(4);
    check_bit("overrun", 1'b0, ovr);
    check_bit("not empty", 1'b0, ne);
    $display("queue test done");
    queue_write(8'hc3);
    mode = `SFS_MODE_SLEEP;
    host.tick(4);
    mode = `SFS_MODE_STDBY;
    host.tick(4);
    check_bit("kept", 1'b1, ne);
    det_en = 1'b1;
    tx_exp = {pat_val[63:56], 8'hc3};
    mode = `SFS_MODE_TX;
    for (i = 0; i < 200 && tx_bit !== 1'b1; i = i + 1) host.tick(1);
    host.tick(1);
    for (i = 15; i >= 0; i = i - 1) begin
      check_bit("tx bit", tx_exp[i], tx_bit);
      host.tick(4);
    end
    for (i = 0; i < 40 && sent !== 1'b1; i = i + 1) host.tick(1);
    check_bit("sent", 1'b1, sent);
    mode = `SFS_MODE_STDBY;
    host.tick(4);
    check_bit("sent", 1'b0, sent);
    queue_write(8'h44);
    mode = `SFS_MODE_RX;
    host.tick(4);
    check_bit("cleared", 1'b0, ne);
    $display("mode and transmit test done");
    pat_len = 3'h1;
    pat_tol = 3'h1;
    send_rx(8'h97);
    check_bit("match", 1'b0, match);
    send_rx(8'hc3);
    check_bit("match", 1'b1, match);
    send_rx(8'h5a);
    host.tick(4);
    check_bit("not empty", 1'b1, ne);
    mode = `SFS_MODE_STDBY;
    host.tick(4);
    check_bit("match", 1'b0, match);
    host.open_frame;
    host.xfer(8'h00, rx);
    host.xfer(8'h00, rx);
    check_byte("rx data", 8'h5a, rx);
    host.close_frame;
    // continuous operation: recognition needs the bit synchroniser
    pkt_mode = 1'b0;
    mode = `SFS_MODE_RX;
    send_rx(8'h96);
    send_rx(8'hc3);
    check_bit("match", 1'b0, match);
    bsync = 1'b1;
    send_rx(8'h96);
    send_rx(8'hc3);
    check_bit("match", 1'b1, match);
    $display("link test done");
    end_of_test;
  end
endmodule

bind sfs_top sfs_monitor mon (.clk_i(clk_i), .nrst_i(nrst_i), .slave_select_n_i(slave_select_n_i),
  .miso_o(miso_o), .miso_oe_n_o(miso_oe_n_o), .reg_addr_o(reg_addr_o), .reg_we_o(reg_we_o),
  .mode_i(mode_i), .packet_mode_i(packet_mode_i), .bitsync_enable_i(bitsync_enable_i),
  .queue_overrun_clear_i(queue_overrun_clear_i), .pattern_detect_enable_i(pattern_detect_enable_i),
  .queue_not_empty_o(queue_not_empty_o), .queue_full_o(queue_full_o),
  .queue_overrun_flag_o(queue_overrun_flag_o), .packet_sent_flag_o(packet_sent_flag_o),
  .pattern_match_flag_o(pattern_match_flag_o));
